// [msm_scan_mux.sv]
/*
 * Multidrop addressable scan port multiplexer: selection protocol,
 * local port network, pass-through bits and output enables.
 * Assumes the backplane test clock is far slower than i_clk.
 */
// Notes on behaviour
// - Notify output high while its data output floats
// - Backplane pass-in goes to single selected port
// - Backplane pass-out comes from single selected port
// - Output enable high floats all local outputs except the pass-through outputs
// - Local clocks copy backplane test clock
// - Local resets gate the backplane reset
// - Local pass-in only ports 0,1, single selection
// - Local pass-out only ports 0,1, single selection
// - Eight slot pins form the device address
// - Level one selects by address, group, broadcast
// - Level two chooses local ports for chain
// - Scan data passes only after both levels
// - Pin mode skips protocol, ports from pins
// - Transparent mode drops pad and own registers
// - Local port can drive lower tier device
// - Master select low makes port zero master
// - Transparent pin loaded into enable bit
// - Pin mode ports come from select pins
`timescale 1ns/10ps
module msm_scan_mux (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   // Backplane ports B0/B1
   input  wire logic [1:0] i_bp_tck,
   input  wire logic [1:0] i_bp_tms,
   input  wire logic [1:0] i_bp_trst_n,
   input  wire logic [1:0] i_bp_tdi,
   input  wire logic [1:0] i_bp_passthru_in_bit0,
   input  wire logic [1:0] i_bp_passthru_in_bit1,
   output logic      [1:0] o_bp_tck,
   output logic      [1:0] o_bp_tck_oe,
   output logic      [1:0] o_bp_tms,
   output logic      [1:0] o_bp_tms_oe,
   output logic      [1:0] o_bp_trst_n,
   output logic      [1:0] o_bp_trst_n_oe,
   output logic      [1:0] o_bp_tdo,
   output logic      [1:0] o_bp_tdo_oe,
   output logic      [1:0] o_bp_tristate_notify,
   output logic      [1:0] o_bp_passthru_out_bit0,
   output logic      [1:0] o_bp_passthru_out_bit1,
   // Local scan ports 1..6
   input  wire logic [5:0] i_lsp_tdi,
   input  wire logic       i_lsp1_passthru_in_bit0,
   input  wire logic       i_lsp1_passthru_in_bit1,
   output logic      [5:0] o_lsp_tck,
   output logic      [5:0] o_lsp_tms,
   output logic      [5:0] o_lsp_trst_n,
   output logic      [5:0] o_lsp_oe,
   output logic      [5:0] o_lsp_tdo,
   output logic      [5:0] o_lsp_tdo_oe,
   output logic      [2:0] o_lsp_tristate_notify,
   output logic            o_lsp1_passthru_out_bit0,
   output logic            o_lsp1_passthru_out_bit1,
   // Configuration pins
   input  wire logic [7:0] i_slot_id,
   input  wire logic       i_local_oe_n,
   input  wire logic       i_master_port_select,
   input  wire logic       i_mode_select_pin,
   input  wire logic [6:0] i_port_select_pins,
   input  wire logic       i_transparent_pin
);

   // =========================================================
   // Input synchronisation
   logic [msm_pkg::SYNC_W-1:0] syn;
   logic [1:0] s_tck, s_tms, s_trst_n, s_tdi, s_a0, s_a1;
   logic [5:0] s_lsp_tdi;
   logic       s_l1_a0, s_l1_a1, s_oe_n, s_mps, s_mode, s_transparent_pin;
   logic [7:0] s_slot;
   logic [6:0] s_port_sel;

   msm_sync #(.W(msm_pkg::SYNC_W)) u_sync (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_d      ({i_bp_tck, i_bp_tms, i_bp_trst_n, i_bp_tdi,
                  i_bp_passthru_in_bit0, i_bp_passthru_in_bit1,
                  i_lsp_tdi, i_lsp1_passthru_in_bit0,
                  i_lsp1_passthru_in_bit1, i_slot_id, i_local_oe_n,
                  i_master_port_select, i_mode_select_pin,
                  i_port_select_pins, i_transparent_pin}),
      .o_q      (syn)
   );

   assign {s_tck, s_tms, s_trst_n, s_tdi, s_a0, s_a1, s_lsp_tdi,
           s_l1_a0, s_l1_a1, s_slot, s_oe_n, s_mps, s_mode,
           s_port_sel, s_transparent_pin} = syn;

   // =========================================================
   // Address match for level one selection
   function automatic logic addr_match(input logic [7:0] a,
                                       input logic [7:0] slot);
      logic [7:0] grp;
      grp = msm_pkg::MCAST_BASE
            | {6'h00, slot[msm_pkg::MCAST_LSB +: 2]};
      addr_match = (a == slot) || (a == msm_pkg::BROADCAST_ADDR)
                   || (a == grp);
   endfunction

   // =========================================================
   // Master port choice
   logic m, o;
   logic bp_tck, bp_tms, bp_trst_n, bp_tdi;
   logic [6:0] port_tdi;

   assign m         = s_mps;
   assign o         = ~s_mps;
   assign bp_tck    = s_tck[m];
   assign bp_tms    = s_tms[m];
   assign bp_trst_n = s_trst_n[m];
   assign bp_tdi    = s_tdi[m];
   assign port_tdi  = {s_lsp_tdi, s_tdi[o]};

   // =========================================================
   // Protocol state
   msm_pkg::msm_state_e state, next_state;
   logic [7:0] sh, next_sh;
   logic       shifting, next_shifting;
   logic [2:0] tms_cnt, next_tms_cnt;
   logic [6:0] sel_ports, next_sel_ports;
   logic       transparent_pin_bit, next_transparent_pin_bit;
   logic [1:0] boot_cnt, next_boot_cnt;
   logic       pad, next_pad;
   logic       tck_q;
   logic       tck_rise, upd, connected, transparent;
   logic [6:0] active_ports, port_tdo;
   logic       chain_ret;

   assign tck_rise    = bp_tck & ~tck_q;
   assign upd         = tck_rise & bp_tms & shifting;
   assign connected   = s_mode | (state == msm_pkg::ST_OPER);
   assign active_ports = !connected ? 7'h00 :
                         s_mode ? s_port_sel : sel_ports;
   assign transparent = transparent_pin_bit & connected;

   // Serial chaining, lowest index nearest backplane input
   always_comb begin
      logic d;
      d        = bp_tdi;
      port_tdo = 7'h00;
      for (int i = 0; i < msm_pkg::NUM_PORTS; i++) begin
         if (active_ports[i]) begin
            port_tdo[i] = d;
            d           = port_tdi[i];
         end
      end
      chain_ret = d;
   end

   always_comb begin
      next_state     = state;
      next_sh        = sh;
      next_shifting  = shifting;
      next_tms_cnt   = tms_cnt;
      next_sel_ports = sel_ports;
      next_transparent_pin_bit = transparent_pin_bit;
      next_pad       = pad;
      next_boot_cnt  = (boot_cnt == 2'h3) ? boot_cnt : boot_cnt + 2'h1;
      if (boot_cnt == msm_pkg::BOOT_LOAD) begin
         next_transparent_pin_bit = s_transparent_pin;
      end
      if (tck_rise) begin
         next_pad = chain_ret;
         if (bp_tms) begin
            next_shifting = 1'b0;
            if (tms_cnt != msm_pkg::PARK_TMS_COUNT) begin
               next_tms_cnt = tms_cnt + 3'h1;
            end
            if (shifting) begin
               case (state)
                  msm_pkg::ST_ADDR: begin
                     if (addr_match(sh, s_slot)) begin
                        next_state = msm_pkg::ST_CONFIG;
                     end
                  end
                  msm_pkg::ST_CONFIG: begin
                     next_sel_ports = sh[msm_pkg::CFG_PORTS_LSB +: 7];
                     next_transparent_pin_bit = sh[msm_pkg::CFG_TRANSPARENT_PIN_BIT];
                     next_state     = msm_pkg::ST_OPER;
                  end
                  msm_pkg::ST_OPER: begin
                  end
                  default: next_state = msm_pkg::ST_ADDR;
               endcase
            end
         end else begin
            next_tms_cnt  = 3'h0;
            next_shifting = 1'b1;
            next_sh       = {bp_tdi, sh[7:1]};
         end
      end
      if (!bp_trst_n || (!s_mode && tms_cnt == msm_pkg::PARK_TMS_COUNT
                         && state != msm_pkg::ST_ADDR)) begin
         next_state     = msm_pkg::ST_ADDR;
         next_sel_ports = 7'h00;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state     <= msm_pkg::ST_ADDR;
         sh        <= 8'h00;
         shifting  <= 1'b0;
         tms_cnt   <= 3'h0;
         sel_ports <= 7'h00;
         transparent_pin_bit <= 1'b0;
         boot_cnt  <= 2'h0;
         pad       <= 1'b0;
         tck_q     <= 1'b0;
      end else begin
         state     <= next_state;
         sh        <= next_sh;
         shifting  <= next_shifting;
         tms_cnt   <= next_tms_cnt;
         sel_ports <= next_sel_ports;
         transparent_pin_bit <= next_transparent_pin_bit;
         boot_cnt  <= next_boot_cnt;
         pad       <= next_pad;
         tck_q     <= bp_tck;
      end
   end

   // =========================================================
   // Output values
   logic [1:0] nx_bp_tck, nx_bp_tck_oe, nx_bp_tms, nx_bp_tms_oe;
   logic [1:0] nx_bp_trst, nx_bp_trst_oe, nx_bp_tdo, nx_bp_tdo_oe;
   logic [1:0] nx_bp_y0, nx_bp_y1;
   logic [5:0] nx_tms, nx_trst, nx_oe, nx_tdo_oe;
   logic       nx_l1_y0, nx_l1_y1, lsp_en, single, trst_gate;

   always_comb begin
      lsp_en    = ~s_oe_n;
      single    = $onehot(active_ports);
      trst_gate = connected ? bp_trst_n : 1'b1;
      nx_oe     = {6{lsp_en}};
      nx_tms    = active_ports[6:1] & {6{bp_tms}};
      nx_trst   = {6{trst_gate}};
      nx_tdo_oe = active_ports[6:1] & {6{lsp_en}};
      // Slave backplane port acts as local port 0
      nx_bp_tck     = {2{bp_tck}};
      nx_bp_tms     = {2{active_ports[0] & bp_tms}};
      nx_bp_trst    = {2{trst_gate}};
      nx_bp_tck_oe  = 2'h0;
      nx_bp_tms_oe  = 2'h0;
      nx_bp_trst_oe = 2'h0;
      nx_bp_tck_oe[o]  = lsp_en;
      nx_bp_tms_oe[o]  = lsp_en;
      nx_bp_trst_oe[o] = lsp_en;
      nx_bp_tdo        = 2'h0;
      nx_bp_tdo_oe     = 2'h0;
      nx_bp_tdo[o]     = port_tdo[0];
      nx_bp_tdo_oe[o]  = lsp_en & active_ports[0];
      nx_bp_tdo[m]     = !connected ? sh[0] :
                         transparent ? chain_ret : pad;
      nx_bp_tdo_oe[m]  = connected | (state != msm_pkg::ST_ADDR);
      // Pass-through bits, single selection only
      nx_bp_y0 = 2'h0;
      nx_bp_y1 = 2'h0;
      nx_l1_y0 = 1'b0;
      nx_l1_y1 = 1'b0;
      if (single && active_ports[0]) begin
         nx_bp_y0[m] = s_a0[o];
         nx_bp_y1[m] = s_a1[o];
         nx_bp_y0[o] = s_a0[m];
         nx_bp_y1[o] = s_a1[m];
      end else if (single && active_ports[1]) begin
         nx_bp_y0[m] = s_l1_a0;
         nx_bp_y1[m] = s_l1_a1;
         nx_l1_y0    = s_a0[m];
         nx_l1_y1    = s_a1[m];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_bp_tck                 <= 2'h0;
         o_bp_tck_oe              <= 2'h0;
         o_bp_tms                 <= 2'h0;
         o_bp_tms_oe              <= 2'h0;
         o_bp_trst_n              <= 2'h0;
         o_bp_trst_n_oe           <= 2'h0;
         o_bp_tdo                 <= 2'h0;
         o_bp_tdo_oe              <= 2'h0;
         o_bp_tristate_notify     <= 2'h3;
         o_bp_passthru_out_bit0   <= 2'h0;
         o_bp_passthru_out_bit1   <= 2'h0;
         o_lsp_tck                <= 6'h00;
         o_lsp_tms                <= 6'h00;
         o_lsp_trst_n             <= 6'h00;
         o_lsp_oe                 <= 6'h00;
         o_lsp_tdo                <= 6'h00;
         o_lsp_tdo_oe             <= 6'h00;
         o_lsp_tristate_notify    <= 3'h7;
         o_lsp1_passthru_out_bit0 <= 1'b0;
         o_lsp1_passthru_out_bit1 <= 1'b0;
      end else begin
         o_bp_tck                 <= nx_bp_tck;
         o_bp_tck_oe              <= nx_bp_tck_oe;
         o_bp_tms                 <= nx_bp_tms;
         o_bp_tms_oe              <= nx_bp_tms_oe;
         o_bp_trst_n              <= nx_bp_trst;
         o_bp_trst_n_oe           <= nx_bp_trst_oe;
         o_bp_tdo                 <= nx_bp_tdo;
         o_bp_tdo_oe              <= nx_bp_tdo_oe;
         o_bp_tristate_notify     <= ~nx_bp_tdo_oe;
         o_bp_passthru_out_bit0   <= nx_bp_y0;
         o_bp_passthru_out_bit1   <= nx_bp_y1;
         o_lsp_tck                <= {6{bp_tck}};
         o_lsp_tms                <= nx_tms;
         o_lsp_trst_n             <= nx_trst;
         o_lsp_oe                 <= nx_oe;
         o_lsp_tdo                <= port_tdo[6:1];
         o_lsp_tdo_oe             <= nx_tdo_oe;
         o_lsp_tristate_notify    <= ~nx_tdo_oe[2:0];
         o_lsp1_passthru_out_bit0 <= nx_l1_y0;
         o_lsp1_passthru_out_bit1 <= nx_l1_y1;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_notify;
      s_oe_n |=> o_lsp_tristate_notify == 3'h7
         && o_bp_tristate_notify[$past(o)] == 1'b1;
   endproperty
   a_notify: assert property (p_notify)
      else $error("notify differs from data enable");

   property p_oe_float;
      s_oe_n |=> (o_lsp_oe == 6'h00) && (o_lsp_tdo_oe == 6'h00);
   endproperty
   a_oe_float: assert property (p_oe_float)
      else $error("local outputs driven while disabled");

   property p_tck_copy;
      1 |=> o_lsp_tck == {6{$past(bp_tck)}};
   endproperty
   a_tck_copy: assert property (p_tck_copy)
      else $error("local clock not a copy");

   property p_trst_gate;
      !connected |=> o_lsp_trst_n == 6'h3f;
   endproperty
   a_trst_gate: assert property (p_trst_gate)
      else $error("reset passed while not connected");

   property p_pass_multi;
      !$onehot(active_ports) |=> !o_lsp1_passthru_out_bit0
         && o_bp_passthru_out_bit0[$past(m)] == 1'b0;
   endproperty
   a_pass_multi: assert property (p_pass_multi)
      else $error("pass-through active without single port");

   property p_pass_l1;
      ($onehot(active_ports) && active_ports[1]) |=>
         o_bp_passthru_out_bit0[$past(m)] == $past(s_l1_a0);
   endproperty
   a_pass_l1: assert property (p_pass_l1)
      else $error("local pass-in not forwarded");

   property p_addr;
      (state == msm_pkg::ST_ADDR && upd && bp_trst_n
       && addr_match(sh, s_slot)) |=> state == msm_pkg::ST_CONFIG;
   endproperty
   a_addr: assert property (p_addr)
      else $error("address match not taken");

   property p_config;
      (state == msm_pkg::ST_CONFIG && upd && bp_trst_n) |=>
         state == msm_pkg::ST_OPER && sel_ports == $past(sh[6:0]);
   endproperty
   a_config: assert property (p_config)
      else $error("port configuration not loaded");

   property p_stitch;
      s_mode |=> o_lsp_tdo_oe ==
         ($past(s_port_sel[6:1]) & {6{~$past(s_oe_n)}});
   endproperty
   a_stitch: assert property (p_stitch)
      else $error("pin mode port choice ignored");

   property p_chain;
      (active_ports[0] && active_ports[1]) |-> port_tdo[1] == port_tdi[0];
   endproperty
   a_chain: assert property (p_chain)
      else $error("chain order wrong");

   property p_master;
      1 |=> o_bp_tck_oe[$past(m)] == 1'b0;
   endproperty
   a_master: assert property (p_master)
      else $error("master port clock driven");

   c_oper:   cover property (state == msm_pkg::ST_OPER);
   c_stitch: cover property (s_mode && active_ports != 7'h00);
   c_single: cover property ($onehot(active_ports));
   c_transparent_pin:  cover property (transparent);

endmodule

// [msm_pkg.sv]
/*
 * Shared constants of the multidrop scan port multiplexer.
 * Assumes one clock domain for the logic; all pins arrive unsynchronised.
 */
package msm_pkg;

   // =========================================================
   // Sizes
   localparam int NUM_LSP   = 6;   // Local ports 1..6 on own pins
   localparam int NUM_PORTS = 7;   // Ports 0..6, port 0 is the slave bp
   localparam int SLOT_W    = 8;
   localparam int SH_W      = 8;
   localparam int SYNC_W    = 39;

   // =========================================================
   // Selection addresses (arbitrary values)
   localparam logic [SH_W-1:0] BROADCAST_ADDR = 8'h3f;
   localparam logic [SH_W-1:0] MCAST_BASE     = 8'h38;
   localparam int              MCAST_LSB      = 6;

   // =========================================================
   // Configuration word layout
   localparam int CFG_PORTS_LSB = 0;
   localparam int CFG_TRANSPARENT_PIN_BIT = 7;

   // =========================================================
   // Timing counts
   localparam logic [2:0] PARK_TMS_COUNT = 3'h5;
   localparam logic [1:0] BOOT_LOAD      = 2'h2;

   typedef enum logic [1:0] {
      ST_ADDR,
      ST_CONFIG,
      ST_OPER
   } msm_state_e;

endpackage

// [msm_sync.sv]
/*
 * Two-stage synchroniser for a group of unrelated level inputs.
 * Assumes each bit is stable long enough to be seen by i_clk.
 */
`timescale 1ns/10ps
module msm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_arst_n,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end

endmodule

// [msm_ctrl_model.sv]
/*
 * Behavioural backplane test controller for the scan port multiplexer.
 * Assumes the bench calls its tasks; pins change on rising i_clk edges.
 */
`timescale 1ns/10ps
module msm_ctrl_model (
   // Clock
   input  wire logic i_clk,
   // Backplane test pins
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst_n
);
   // =========================================================
   // Idle levels: clock still, pulled-up lines high
   initial begin
      o_tck    = 1'b0;
      o_tms    = 1'b1;
      o_tdi    = 1'b1;
      o_trst_n = 1'b1;
   end

   // =========================================================
   // One test clock period of 320 ns, data set while clock low
   task automatic tck_edge(input logic tms, input logic tdi);
      @(posedge i_clk);
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (3) @(posedge i_clk);
      o_tck <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_tck <= 1'b0;
   endtask

   // Eight bits low first, then one update edge
   task automatic send_word(input logic [7:0] w);
      for (int i = 0; i < 8; i++) begin
         tck_edge(1'b0, w[i]);
      end
      tck_edge(1'b1, 1'b1);
   endtask

   // Held-high select drops the connection
   task automatic park();
      repeat (5) tck_edge(1'b1, 1'b1);
   endtask

   task automatic set_pins(input logic tck, input logic trst_n);
      @(posedge i_clk);
      o_tck    <= tck;
      o_trst_n <= trst_n;
   endtask
endmodule

// [test_msm_scan_mux.sv]
/*
 * Self-checking bench of the scan port multiplexer.
 * Assumes the controller model sits on the master backplane port.
 */
`timescale 1ns/10ps
module test_msm_scan_mux;
   // =========================================================
   // Signals
   logic       i_clk, i_arst_n, i_local_oe_n, i_transparent_pin;
   logic       i_master_port_select, i_mode_select_pin;
   logic [1:0] i_bp_tck, i_bp_tms, i_bp_trst_n, i_bp_tdi;
   logic [1:0] i_bp_passthru_in_bit0, i_bp_passthru_in_bit1;
   logic [5:0] i_lsp_tdi;
   logic       i_lsp1_passthru_in_bit0, i_lsp1_passthru_in_bit1;
   logic [7:0] i_slot_id;
   logic [6:0] i_port_select_pins;
   logic [1:0] o_bp_tck, o_bp_tck_oe, o_bp_tms, o_bp_tms_oe, o_bp_trst_n;
   logic [1:0] o_bp_trst_n_oe, o_bp_tdo, o_bp_tdo_oe, o_bp_tristate_notify;
   logic [1:0] o_bp_passthru_out_bit0, o_bp_passthru_out_bit1;
   logic [5:0] o_lsp_tck, o_lsp_tms, o_lsp_trst_n, o_lsp_oe, o_lsp_tdo;
   logic [5:0] o_lsp_tdo_oe;
   logic [2:0] o_lsp_tristate_notify;
   logic       o_lsp1_passthru_out_bit0, o_lsp1_passthru_out_bit1;
   logic       m_tck, m_tms, m_tdi, m_trst_n;
   logic [1:0] bp_pt;
   logic [7:0] addr [3] = '{8'h5a, 8'h39, 8'h3f};
   int         bad_count, comparisons;

   always #20 i_clk = ~i_clk;

   // Controller on the master port, slave port clock low, other lines pulled up
   always_comb begin
      i_bp_tck  = 2'b00;
      i_bp_tms  = 2'b11;
      i_bp_trst_n = 2'b11;
      i_bp_tdi  = 2'b11;
      i_bp_passthru_in_bit0 = 2'b11;
      i_bp_passthru_in_bit1 = 2'b11;
      i_bp_tck[i_master_port_select] = m_tck;
      i_bp_tms[i_master_port_select] = m_tms;
      i_bp_trst_n[i_master_port_select] = m_trst_n;
      i_bp_tdi[i_master_port_select] = m_tdi;
      i_bp_passthru_in_bit0[i_master_port_select] = bp_pt[0];
      i_bp_passthru_in_bit1[i_master_port_select] = bp_pt[1];
   end

   msm_scan_mux msm_scan_mux_inst (
      .i_clk, .i_arst_n, .i_bp_tck, .i_bp_tms, .i_bp_trst_n, .i_bp_tdi,
      .i_bp_passthru_in_bit0, .i_bp_passthru_in_bit1, .o_bp_tck,
      .o_bp_tck_oe, .o_bp_tms, .o_bp_tms_oe, .o_bp_trst_n, .o_bp_trst_n_oe,
      .o_bp_tdo, .o_bp_tdo_oe, .o_bp_tristate_notify,
      .o_bp_passthru_out_bit0, .o_bp_passthru_out_bit1, .i_lsp_tdi,
      .i_lsp1_passthru_in_bit0, .i_lsp1_passthru_in_bit1, .o_lsp_tck,
      .o_lsp_tms, .o_lsp_trst_n, .o_lsp_oe, .o_lsp_tdo, .o_lsp_tdo_oe,
      .o_lsp_tristate_notify, .o_lsp1_passthru_out_bit0,
      .o_lsp1_passthru_out_bit1, .i_slot_id, .i_local_oe_n,
      .i_master_port_select, .i_mode_select_pin, .i_port_select_pins,
      .i_transparent_pin
   );

   msm_ctrl_model msm_ctrl_model_inst (
      .i_clk, .o_tck(m_tck), .o_tms(m_tms), .o_tdi(m_tdi),
      .o_trst_n(m_trst_n)
   );

   // =========================================================
   // Tasks
   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic settle();
      repeat (12) @(posedge i_clk);
      #1;
   endtask

   task automatic do_reset(input logic mode, input logic ms,
                           input logic [6:0] ps, input logic tr);
      @(posedge i_clk);
      i_arst_n             <= 1'b0;
      i_mode_select_pin    <= mode;
      i_master_port_select <= ms;
      i_port_select_pins   <= ps;
      i_transparent_pin    <= tr;
      repeat (16) @(posedge i_clk);
      #1;
      chk("notify_rst", 8'h1f,
          {3'h0, o_lsp_tristate_notify, o_bp_tristate_notify});
      chk("lsp_oe_rst", 8'h00, 8'(o_lsp_oe));
      @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      settle();
   endtask

   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Tests need some 1000 cycles; twenty times that means a hang
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      final_report();
   end

   // =========================================================
   // Tests
   initial begin
      i_clk = 1'b0;
      i_arst_n = 1'b0;
      i_local_oe_n = 1'b0;
      i_transparent_pin = 1'b0;
      i_master_port_select = 1'b0;
      i_mode_select_pin = 1'b1;
      i_port_select_pins = 7'h00;
      i_lsp_tdi = 6'h3f;
      i_lsp1_passthru_in_bit0 = 1'b1;
      i_lsp1_passthru_in_bit1 = 1'b1;
      i_slot_id = 8'h5a;
      bp_pt = 2'b11;
      bad_count = 0;
      comparisons = 0;

      // Pin mode, port 1 alone, backplane 0 master
      do_reset(1'b1, 1'b0, 7'h02, 1'b0);
      chk("lsp_tdo_oe", 8'h01, 8'(o_lsp_tdo_oe));
      chk("lsp_notify", 8'h06, 8'(o_lsp_tristate_notify));
      chk("bp_tdo_oe", 8'h01, 8'(o_bp_tdo_oe));
      msm_ctrl_model_inst.set_pins(1'b1, 1'b1);
      settle();
      chk("lsp_tck_high", 8'h3f, 8'(o_lsp_tck));
      chk("bp_tck_high", 8'h03, 8'(o_bp_tck));
      msm_ctrl_model_inst.set_pins(1'b0, 1'b0);
      settle();
      chk("lsp_tck_low", 8'h00, 8'(o_lsp_tck));
      chk("lsp_trst_n", 8'h00, 8'(o_lsp_trst_n));
      chk("bp_trst_n", 8'h00, 8'(o_bp_trst_n));
      msm_ctrl_model_inst.set_pins(1'b0, 1'b1);
      for (int v = 0; v < 4; v++) begin
         @(posedge i_clk);
         bp_pt <= 2'(v);
         i_lsp1_passthru_in_bit0 <= ~v[0];
         i_lsp1_passthru_in_bit1 <= ~v[1];
         settle();
         chk("lsp1_pt_out", 8'(v), {6'h0, o_lsp1_passthru_out_bit1,
             o_lsp1_passthru_out_bit0});
         chk("bp_pt_out", 8'(3 - v), {6'h0, o_bp_passthru_out_bit1[0],
             o_bp_passthru_out_bit0[0]});
      end
      chk("lsp_trst_n_hi", 8'h3f, 8'(o_lsp_trst_n));
      @(posedge i_clk);
      i_lsp_tdi <= 6'h3e;
      repeat (2) msm_ctrl_model_inst.tck_edge(1'b0, 1'b1);
      settle();
      chk("lsp_tdo_p1", 8'h01, 8'(o_lsp_tdo[0]));
      chk("bp_tdo_p1", 8'h00, 8'(o_bp_tdo[0]));
      @(posedge i_clk);
      i_local_oe_n <= 1'b1;
      settle();
      chk("lsp_oe_off", 8'h00, 8'(o_lsp_oe));
      chk("lsp_tdo_oe_off", 8'h00, 8'(o_lsp_tdo_oe));
      chk("lsp_notify_off", 8'h07, 8'(o_lsp_tristate_notify));
      @(posedge i_clk);
      i_local_oe_n <= 1'b0;
      $display("Test pin mode single port done");

      // Transparent pin mode, ports 1 and 2 in series
      do_reset(1'b1, 1'b0, 7'h06, 1'b1);
      chk("lsp1_pt_multi", 8'h00, {6'h0, o_lsp1_passthru_out_bit1,
          o_lsp1_passthru_out_bit0});
      chk("bp_pt_multi", 8'h00, {6'h0, o_bp_passthru_out_bit1[0],
          o_bp_passthru_out_bit0[0]});
      for (int k = 0; k < 2; k++) begin
         @(posedge i_clk);
         i_lsp_tdi <= (k == 0) ? 6'h01 : 6'h02;
         msm_ctrl_model_inst.tck_edge(1'b0, k[0]);
         settle();
         chk("chain_tdo", (k == 0) ? 8'h02 : 8'h01,
             8'(o_lsp_tdo[1:0]));
         chk("chain_ret", 8'(k), 8'(o_bp_tdo[0]));
      end
      @(posedge i_clk);
      i_lsp_tdi <= 6'h00;
      settle();
      chk("transp_ret", 8'h00, 8'(o_bp_tdo[0]));
      $display("Test transparent chain done");

      // Addressed mode, backplane 1 master
      do_reset(1'b0, 1'b1, 7'h00, 1'b0);
      chk("bp_tdo_oe_idle", 8'h00, 8'(o_bp_tdo_oe));
      msm_ctrl_model_inst.send_word(8'h5b);
      settle();
      chk("bp_tdo_oe_miss", 8'h00, 8'(o_bp_tdo_oe));
      foreach (addr[i]) begin
         msm_ctrl_model_inst.send_word(addr[i]);
         settle();
         chk("bp_tdo_oe_sel", 8'h02, 8'(o_bp_tdo_oe));
         chk("bp_notify_sel", 8'h01, 8'(o_bp_tristate_notify));
         chk("lsp_tdo_oe_l1", 8'h00, 8'(o_lsp_tdo_oe));
         chk("lsp_tms_l1", 8'h00, 8'(o_lsp_tms));
         // Last pass also sets the transparent bit
         msm_ctrl_model_inst.send_word({(i == 2), 7'h03});
         settle();
         chk("lsp_tdo_oe_l2", 8'h01, 8'(o_lsp_tdo_oe));
         chk("bp_tdo_oe_l2", 8'h03, 8'(o_bp_tdo_oe));
         chk("bp_tck_oe", 8'h01, 8'(o_bp_tck_oe));
         chk("lsp_tms_l2", 8'h01, 8'(o_lsp_tms));
         chk("bp_tms_l2", 8'h03, 8'(o_bp_tms));
         chk("bp_slave_oe", 8'h15, {2'h0, o_bp_trst_n_oe, o_bp_tms_oe,
             o_bp_tck_oe});
         chk("bp_slave_tdo", 8'h01, 8'(o_bp_tdo[0]));
         chk("bp_tdo_pad", 8'(i != 2), 8'(o_bp_tdo[1]));
         msm_ctrl_model_inst.park();
         settle();
         chk("bp_tdo_oe_park", 8'h00, 8'(o_bp_tdo_oe));
      end
      $display("Test addressed mode done");
      final_report();
   end
endmodule
